// [core/vpic_defs.vh]
`ifndef VPIC_DEFS_VH
`define VPIC_DEFS_VH

// source count and word layout
`define VPIC_NSRC 72
`define VPIC_VEC_OFFSET 7'h08
`define VPIC_PRIO_W 3
`define VPIC_PRIO_RESET 3'h4

// register word indices (byte address is four times the index)
`define VPIC_IDX_CTRL1 6'h00
`define VPIC_IDX_CTRL2 6'h01
`define VPIC_IDX_FLAG0 6'h02
`define VPIC_IDX_EN0 6'h07
`define VPIC_IDX_PRIO0 6'h0C
`define VPIC_IDX_READBACK 6'h1E
`define VPIC_IDX_STATUS 6'h1F
`define VPIC_IDX_CORE 6'h20
`define VPIC_NUM_FLAG_REGS 5
`define VPIC_NUM_PRIO_REGS 18

// field positions
`define VPIC_CTRL1_NEST_BIT 15
`define VPIC_CTRL1_TRAP_LSB 1
`define VPIC_CTRL2_ALT_BIT 15
`define VPIC_STATUS_IPL_LSB 5
`define VPIC_CORE_CPU_LEVEL_MSB_BIT 3
`define VPIC_RB_LEVEL_LSB 8

// vector table bases
`define VPIC_PRI_TBL_BASE 24'h000014
`define VPIC_ALT_TBL_BASE 24'h000114

// external pin request numbers
`define VPIC_EXT0_IRQ 0
`define VPIC_EXT1_IRQ 20
`define VPIC_EXT2_IRQ 29

`endif

// [core/vpic_arb.v]
`timescale 1ns/1ps
`default_nettype none

// picks the winning pending source: highest priority, lowest number on ties
module vpic_arb (
	input wire [71:0] req, // flagged and enabled sources
	input wire [215:0] prio, // 3-bit priority per source
	input wire [3:0] cur_level, // current cpu level, 4 bits
	output reg found, // a source beats the cpu level
	output reg [6:0] idx, // winning request number
	output reg [2:0] level // winning priority
);

	integer i;
	reg [2:0] p;

	// scan downward so an equal priority at a lower number overwrites
	always @* begin
		p = 3'h0;
		found = 1'b0;
		idx = 7'h00;
		level = 3'h0;
		for (i = 71; i >= 0; i = i - 1) begin
			p = prio[i*3 +: 3];
			// zero priority never wins, and must exceed cpu level
			if (req[i] && (p != 3'h0) && ({1'b0, p} > cur_level) && (p >= level)) begin
				found = 1'b1;
				idx = i[6:0];
				level = p;
			end
		end
	end

endmodule // vpic_arb

`default_nettype wire

// [core/vpic_ctrl.v]
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "vpic_defs.vh"

// Notes on behaviour
// - vector number is request number plus eight
// - handler address from primary or alternate table
// - thirty-three controller registers in the map
// - control one: nesting disable, trap flags
// - control two: pin edges, alternate table select
// - hardware sets flags, software write clears
// - one enable bit per source
// - priority 1..7, zero disables the source
// - any source takes any priority level
// - readback latches vector and new level
// - bits follow request number order
// - status bits 7:5 hold writable cpu level
// - fourth level bit read-only in core control
// - priority word four field layout, gaps zero
// - priority fields reset to four
module vpic_ctrl (
	input wire ref_clk, // system clock, 10 MHz
	input wire rst_b, // synchronous reset, active low
	input wire [5:0] avs_address, // word index
	input wire avs_read, // read request
	input wire avs_write, // write request
	input wire [31:0] avs_writedata, // write data
	input wire [3:0] avs_byteenable, // byte lanes
	output reg [31:0] avs_readdata, // read data
	output reg avs_waitrequest, // stall until answer
	input wire [71:0] src_event, // peripheral event pulses
	input wire [2:0] ext_pin, // external request pins
	input wire [3:0] trap_event, // processor trap pulses
	input wire irq_ack, // core takes the presented interrupt
	output reg irq_valid, // an interrupt is presented
	output reg [6:0] irq_vector, // presented vector number
	output reg [3:0] irq_level, // presented new cpu level
	output reg [23:0] irq_handler_addr, // handler fetch address
	output reg [3:0] cpu_level // current cpu level
);

	// register state
	reg nest_dis_q; // nesting disable
	reg [3:0] trap_q; // sticky trap flags
	reg alt_tbl_q; // alternate table select
	reg [2:0] ext_edge_q; // 1 = falling edge request
	reg [71:0] flag_q; // request flags
	reg [71:0] flag_d;
	reg [71:0] en_q; // enable bits
	reg [71:0] en_d;
	reg [215:0] prio_q; // priority fields
	reg [215:0] prio_d;
	reg [2:0] ipl_q; // cpu level low bits
	reg [2:0] ext_prev_q; // pin history for edge detect
	reg [6:0] rb_vec_q; // readback vector
	reg [3:0] rb_lvl_q; // readback level

	// bus handshake
	wire req_any = avs_read | avs_write; // request pending
	wire wr_fire = avs_write & ~avs_waitrequest; // write takes effect
	wire [15:0] wdat = avs_writedata[15:0]; // only low half is mapped

	// arbiter wires
	wire arb_found;
	wire [6:0] arb_idx;
	wire [2:0] arb_level;
	wire cpu_level_msb = |trap_q; // traps lift level to eight or above
	wire [3:0] cur_level = {cpu_level_msb, ipl_q};

	// word select against an integer index
	function word_hit;
		input [5:0] a;
		input integer w;
		begin
			word_hit = (a == w[5:0]);
		end
	endfunction

	// byte lane covering a bit of a 16-bit word
	function lane_ok;
		input [3:0] be;
		input integer b;
		begin
			lane_ok = (b < 8) ? be[0] : be[1];
		end
	endfunction

	// edge seen on one external pin, per polarity
	function pin_edge;
		input cur;
		input prev;
		input falling;
		begin
			pin_edge = falling ? (prev & ~cur) : (cur & ~prev);
		end
	endfunction

	vpic_arb u_arb (
		.req(flag_q & en_q),
		.prio(prio_q),
		.cur_level(cur_level),
		.found(arb_found),
		.idx(arb_idx),
		.level(arb_level)
	);

	integer i;
	integer j; // read mux index, kept apart from the next-state loop
	reg [71:0] hw_set; // hardware set requests
	reg [15:0] rd_word; // selected read word

	// hardware event set terms, pins folded into their request numbers
	always @* begin
		hw_set = src_event;
		hw_set[`VPIC_EXT0_IRQ] = src_event[`VPIC_EXT0_IRQ] |
			pin_edge(ext_pin[0], ext_prev_q[0], ext_edge_q[0]);
		hw_set[`VPIC_EXT1_IRQ] = src_event[`VPIC_EXT1_IRQ] |
			pin_edge(ext_pin[1], ext_prev_q[1], ext_edge_q[1]);
		hw_set[`VPIC_EXT2_IRQ] = src_event[`VPIC_EXT2_IRQ] |
			pin_edge(ext_pin[2], ext_prev_q[2], ext_edge_q[2]);
	end

	// next flags, enables and priorities; set always wins over a clear
	always @* begin
		flag_d = flag_q;
		en_d = en_q;
		prio_d = prio_q;
		for (i = 0; i < `VPIC_NSRC; i = i + 1) begin
			// source i sits at bit i%16 of word i/16
			if (wr_fire && word_hit(avs_address, `VPIC_IDX_FLAG0 + i / 16) &&
				lane_ok(avs_byteenable, i % 16)) begin
				flag_d[i] = wdat[i % 16];
			end
			if (wr_fire && word_hit(avs_address, `VPIC_IDX_EN0 + i / 16) &&
				lane_ok(avs_byteenable, i % 16)) begin
				en_d[i] = wdat[i % 16];
			end
			// four fields of three bits per word, gap bit above each
			if (wr_fire && word_hit(avs_address, `VPIC_IDX_PRIO0 + i / 4) &&
				lane_ok(avs_byteenable, (i % 4) * 4)) begin
				prio_d[i*3 +: 3] = wdat[(i % 4) * 4 +: 3];
			end
			flag_d[i] = flag_d[i] | hw_set[i];
		end
	end

	// read word mux; unmapped indices read zero
	always @* begin
		rd_word = 16'h0000;
		if (avs_address == `VPIC_IDX_CTRL1) begin
			rd_word[`VPIC_CTRL1_NEST_BIT] = nest_dis_q;
			rd_word[`VPIC_CTRL1_TRAP_LSB +: 4] = trap_q;
		end else if (avs_address == `VPIC_IDX_CTRL2) begin
			rd_word[`VPIC_CTRL2_ALT_BIT] = alt_tbl_q;
			rd_word[2:0] = ext_edge_q;
		end else if (avs_address == `VPIC_IDX_READBACK) begin
			rd_word[6:0] = rb_vec_q;
			rd_word[`VPIC_RB_LEVEL_LSB +: 4] = rb_lvl_q;
		end else if (avs_address == `VPIC_IDX_STATUS) begin
			rd_word[`VPIC_STATUS_IPL_LSB +: 3] = ipl_q;
		end else if (avs_address == `VPIC_IDX_CORE) begin
			rd_word[`VPIC_CORE_CPU_LEVEL_MSB_BIT] = cpu_level_msb;
		end else begin
			for (j = 0; j < `VPIC_NSRC; j = j + 1) begin
				if (word_hit(avs_address, `VPIC_IDX_FLAG0 + j / 16)) begin
					rd_word[j % 16] = flag_q[j];
				end
				if (word_hit(avs_address, `VPIC_IDX_EN0 + j / 16)) begin
					rd_word[j % 16] = en_q[j];
				end
				if (word_hit(avs_address, `VPIC_IDX_PRIO0 + j / 4)) begin
					rd_word[(j % 4) * 4 +: 3] = prio_q[j*3 +: 3];
				end
			end
		end
	end

	// avalon slave: one wait cycle, then the answer stands for one edge
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			if (req_any && avs_waitrequest) begin
				// first cycle of a request: capture data, release stall
				avs_waitrequest <= 1'b0;
				avs_readdata <= {16'h0000, rd_word};
			end else begin
				// answer taken at this edge; stall the next request again
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// source table state
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			flag_q <= 72'h000000000000000000;
			en_q <= 72'h000000000000000000;
			prio_q <= {`VPIC_NSRC{`VPIC_PRIO_RESET}};
			ext_prev_q <= ext_pin; // a pin idling high gives no false edge
		end else begin
			flag_q <= flag_d;
			en_q <= en_d;
			prio_q <= prio_d;
			ext_prev_q <= ext_pin; // pins are synchronous to ref_clk
		end
	end

	// global control words
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			nest_dis_q <= 1'b0;
			trap_q <= 4'h0;
			alt_tbl_q <= 1'b0;
			ext_edge_q <= 3'h0;
		end else begin
			if (wr_fire && avs_address == `VPIC_IDX_CTRL1) begin
				if (avs_byteenable[1]) begin
					nest_dis_q <= wdat[`VPIC_CTRL1_NEST_BIT];
				end
				if (avs_byteenable[0]) begin
					// trap flags clear by write, a new trap still sets
					trap_q <= wdat[`VPIC_CTRL1_TRAP_LSB +: 4] | trap_event;
				end else begin
					trap_q <= trap_q | trap_event;
				end
			end else begin
				trap_q <= trap_q | trap_event;
			end
			if (wr_fire && avs_address == `VPIC_IDX_CTRL2) begin
				if (avs_byteenable[1]) begin
					alt_tbl_q <= wdat[`VPIC_CTRL2_ALT_BIT];
				end
				if (avs_byteenable[0]) begin
					ext_edge_q <= wdat[2:0];
				end
			end
		end
	end

	// cpu level: software writes it, acceptance raises it
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			ipl_q <= 3'h0;
		end else if (irq_ack && irq_valid) begin
			// nesting off pins the level at seven so nothing preempts
			ipl_q <= nest_dis_q ? 3'h7 : irq_level[2:0];
		end else if (wr_fire && avs_address == `VPIC_IDX_STATUS && avs_byteenable[0]) begin
			ipl_q <= wdat[`VPIC_STATUS_IPL_LSB +: 3];
		end
	end

	// readback and presentation to the core, all registered
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			rb_vec_q <= 7'h00;
			rb_lvl_q <= 4'h0;
			irq_valid <= 1'b0;
			irq_vector <= 7'h00;
			irq_level <= 4'h0;
			irq_handler_addr <= 24'h000000;
			cpu_level <= 4'h0;
		end else begin
			cpu_level <= cur_level;
			irq_valid <= arb_found;
			if (arb_found) begin
				rb_vec_q <= arb_idx + `VPIC_VEC_OFFSET;
				rb_lvl_q <= {1'b0, arb_level};
				irq_vector <= arb_idx + `VPIC_VEC_OFFSET;
				irq_level <= {1'b0, arb_level};
				// two bytes per entry in either table
				irq_handler_addr <= (alt_tbl_q ? `VPIC_ALT_TBL_BASE : `VPIC_PRI_TBL_BASE) +
					{16'h0000, arb_idx, 1'b0};
			end
		end
	end

endmodule // vpic_ctrl

`default_nettype wire

// [tb/vpic_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the register handshake and the presented interrupt
module vpic_ctrl_chk (
	input wire logic ref_clk, // system clock
	input wire logic rst_b, // sync reset, low
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic [3:0] trap_event, // trap pulses
	input wire logic irq_ack, // core take
	input wire logic irq_valid, // presented
	input wire logic [6:0] irq_vector, // vector
	input wire logic [3:0] irq_level, // new level
	input wire logic [23:0] irq_handler_addr, // fetch address
	input wire logic [3:0] cpu_level // current level
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// table offset, twice the request number; both tables share it
	logic [23:0] off;
	assign off = {16'h0000, irq_vector, 1'b0} - 24'h000010;
	// request seen while stalled, then a single answer cycle
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_hand; s_req |=> s_ans; endproperty
	a_hand: assert property (p_hand) else $error("handshake slip");
	property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_hi; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper half not zero");
	property p_vec; irq_valid |-> irq_vector >= 7'h08 && irq_vector <= 7'h4F; endproperty
	a_vec: assert property (p_vec) else $error("vector out of range");
	property p_addr;
		irq_valid |-> irq_handler_addr == 24'h000014 + off || irq_handler_addr == 24'h000114 + off;
	endproperty
	a_addr: assert property (p_addr) else $error("handler address wrong");
	property p_lvl; irq_valid |-> irq_level != 4'h0 && !irq_level[3]; endproperty
	a_lvl: assert property (p_lvl) else $error("zero priority presented");
	property p_ack; irq_ack && irq_valid |-> ##2 cpu_level[2:0] >= $past(irq_level[2:0], 2); endproperty
	a_ack: assert property (p_ack) else $error("level not raised");
	property p_trap; trap_event != 4'h0 |-> ##[1:2] cpu_level[3]; endproperty
	a_trap: assert property (p_trap) else $error("trap level missing");
	property p_rst; $rose(rst_b) |-> avs_waitrequest && !irq_valid && cpu_level == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // vpic_ctrl_chk
bind vpic_ctrl vpic_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.trap_event(trap_event), .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
	.irq_level(irq_level), .irq_handler_addr(irq_handler_addr), .cpu_level(cpu_level));
`default_nettype wire

// [tb/vpic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// processor side: takes a presented interrupt after a set wait
module vpic_core_model (
	input wire logic ref_clk, // system clock
	input wire logic rst_b, // sync reset, low
	input wire logic en, // answers only when set
	input wire logic [3:0] delay, // wait before taking
	input wire logic irq_valid, // presented interrupt
	output logic irq_ack // one-cycle take pulse
);
	logic [3:0] cnt_q; // wait counter
	// restart after each take, so a slow level drop is not taken twice
	always @(posedge ref_clk) begin
		irq_ack <= 1'b0;
		if (!rst_b || !en || !irq_valid || irq_ack) begin
			cnt_q <= 4'h0;
		end else if (cnt_q == delay) begin
			irq_ack <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // vpic_core_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0; // 10 MHz
	logic rst_b = 1'b0; // held low at start
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [71:0] src_event = 72'h0; // peripheral pulses
	logic [2:0] ext_pin = 3'h0;
	logic [3:0] trap_event = 4'h0;
	logic irq_ack, irq_valid, core_en = 1'b0;
	logic [6:0] irq_vector;
	logic [3:0] irq_level, cpu_level;
	logic [23:0] irq_handler_addr;
	logic [15:0] exp_q[$]; // pending read results
	logic [31:0] r;
	integer seed = 32'h9FE328C7;
	int errors = 0, checks_done = 0, cycles = 0, n, p;
	always #50 ref_clk = ~ref_clk;
	vpic_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.src_event(src_event), .ext_pin(ext_pin), .trap_event(trap_event), .irq_ack(irq_ack),
		.irq_valid(irq_valid), .irq_vector(irq_vector), .irq_level(irq_level),
		.irq_handler_addr(irq_handler_addr), .cpu_level(cpu_level));
	vpic_core_model u_core (.ref_clk(ref_clk), .rst_b(rst_b), .en(core_en), .delay(4'h6),
		.irq_valid(irq_valid), .irq_ack(irq_ack));
	task results;
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus cycle, held until waitrequest is sampled low
	task bus(input logic rw, input int a, input int d);
		@(posedge ref_clk);
		avs_address <= 6'(a);
		avs_writedata <= {16'h0000, 16'(d)};
		avs_read <= rw;
		avs_write <= !rw;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input int a, input int d);
		bus(1'b0, a, d);
	endtask
	task rd(input int a, input int e);
		exp_q.push_back(16'(e));
		bus(1'b1, a, 0);
	endtask
	// one-cycle event, then time for flag and presentation to settle
	task pulse(input int k);
		@(posedge ref_clk);
		src_event[k] <= 1'b1;
		@(posedge ref_clk);
		src_event <= 72'h0;
		repeat (4) @(posedge ref_clk);
	endtask
	// read answers are taken at the edge that ends the stall; also the hang guard
	always @(posedge ref_clk) begin
		if (avs_read && avs_waitrequest === 1'b0)
			chk("readdata", avs_readdata, {16'h0000, exp_q.pop_front()});
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results;
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(18, 32'h4444);
		rd(12, 32'h4444);
		rd(33, 0);
		wr(18, 32'hFFFF);
		rd(18, 32'h7777);
		r = $random(seed);
		wr(18, r[15:0]);
		rd(18, r[15:0] & 16'h7777);
		wr(18, 32'h4444);
		// rising edge on pin 0 sets flag bit 0
		@(posedge ref_clk);
		ext_pin <= 3'h1;
		repeat (3) @(posedge ref_clk);
		rd(2, 32'h0001);
		wr(2, 0);
		rd(2, 0);
		// pin 1 answers only its falling edge, pin 2 its rising edge
		wr(1, 32'h0002);
		@(posedge ref_clk);
		ext_pin <= 3'h7;
		repeat (2) @(posedge ref_clk);
		rd(3, 32'h2000);
		@(posedge ref_clk);
		ext_pin <= 3'h1;
		repeat (2) @(posedge ref_clk);
		rd(3, 32'h2010);
		wr(3, 0);
		// random source and level; the last pass uses level zero
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			n = r[15:0] % 72;
			p = (i == 5) ? 0 : 1 + r[18:16] % 7;
			wr(1, i[0] ? 32'h8000 : 0);
			wr(12 + n / 4, p << (4 * (n % 4)));
			wr(7 + n / 16, 1 << (n % 16));
			pulse(n);
			chk("irq_valid", irq_valid, p != 0);
			if (p != 0) begin
				chk("irq_vector", irq_vector, n + 8);
				chk("irq_level", irq_level, p);
				chk("handler", irq_handler_addr, (i[0] ? 32'h114 : 32'h14) + 2 * n);
				rd(30, (p << 8) | (n + 8));
				wr(31, p << 5);
				repeat (3) @(posedge ref_clk);
				chk("masked", irq_valid, 0);
				wr(31, 0);
			end
			rd(2 + n / 16, 1 << (n % 16));
			wr(2 + n / 16, 0);
			wr(7 + n / 16, 0);
			wr(12 + n / 4, 32'h4444);
		end
		// equal levels go to the lower number, a higher level beats it
		wr(13, 32'h0330);
		wr(7, 32'h0060);
		pulse(6);
		pulse(5);
		chk("tie vector", irq_vector, 7'h0D);
		wr(13, 32'h0430);
		repeat (3) @(posedge ref_clk);
		chk("level vector", irq_vector, 7'h0E);
		wr(2, 0);
		wr(7, 0);
		wr(13, 32'h4444);
		// core takes a level-6 request from source 5
		core_en <= 1'b1;
		wr(13, 32'h0060);
		wr(7, 32'h0020);
		pulse(5);
		repeat (12) @(posedge ref_clk);
		chk("cpu_level", cpu_level, 4'h6);
		rd(31, 32'h00C0);
		// nesting off: the next take pins the level at seven
		wr(0, 32'h8000);
		wr(31, 0);
		repeat (12) @(posedge ref_clk);
		chk("nest level", cpu_level, 4'h7);
		rd(0, 32'h8000);
		core_en <= 1'b0;
		wr(2, 0);
		wr(31, 0);
		// trap raises the read-only fourth level bit
		@(posedge ref_clk);
		trap_event <= 4'h1;
		@(posedge ref_clk);
		trap_event <= 4'h0;
		repeat (3) @(posedge ref_clk);
		chk("trap level", cpu_level[3], 1'b1);
		wr(32, 0);
		rd(32, 32'h0008);
		wr(0, 0);
		results;
	end
endmodule // tb
`default_nettype wire
